// ---- common/ccs_pkg.sv ----
package ccs_pkg;

  localparam int           CCS_REG_W       = 16;
  localparam int           CCS_PIX_W       = 8;
  localparam logic [15:0]  CCS_RESET_VALUE = 16'h0000;

  // bit positions inside the context switch control register
  localparam int           CCS_BIT_HBLANK  = 0;
  localparam int           CCS_BIT_VBLANK  = 1;
  localparam int           CCS_BIT_LED     = 2;
  localparam int           CCS_BIT_RDMODE  = 3;
  localparam int           CCS_BIT_FBLANK  = 6;
  localparam int           CCS_BIT_XENON   = 7;
  localparam int           CCS_BIT_GAMMA   = 8;
  localparam int           CCS_BIT_FMT2    = 9;
  localparam int           CCS_BIT_RESIZE  = 10;
  localparam int           CCS_BIT_DEFECT  = 12;
  localparam int           CCS_BIT_RESTART = 15;

  // bits that exist; all others are reserved and read as zero
  localparam logic [15:0]  CCS_IMPL_MASK   = 16'h97cf;

  localparam logic         CCS_CTX_A       = 1'b0;
  localparam logic         CCS_CTX_B       = 1'b1;

  typedef struct packed {
    logic defect;
    logic resize;
    logic fmt2;
    logic gamma;
    logic readMode;
    logic vBlank;
    logic hBlank;
  } ccs_ctx_s;

  typedef struct packed {
    logic                 valid;
    logic                 frameStart;
    logic [CCS_PIX_W-1:0] data;
  } ccs_pix_s;

  function automatic ccs_ctx_s ccs_ctx_of(input logic [15:0] r);
    ccs_ctx_s c;
    c.defect   = r[CCS_BIT_DEFECT];
    c.resize   = r[CCS_BIT_RESIZE];
    c.fmt2     = r[CCS_BIT_FMT2];
    c.gamma    = r[CCS_BIT_GAMMA];
    c.readMode = r[CCS_BIT_RDMODE];
    c.vBlank   = r[CCS_BIT_VBLANK];
    c.hBlank   = r[CCS_BIT_HBLANK];
    return c;
  endfunction : ccs_ctx_of

endpackage : ccs_pkg

// ---- design/ccs_restart_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none
module ccs_restart_ctrl
  import ccs_pkg::*;
(
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic launch,
  input  wire logic sensorRestartDone,
  output logic      restartReq,
  output logic      restartClear
);

  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT} ccs_rst_state_e;

  ccs_rst_state_e state;
  ccs_rst_state_e next_state;

  always_comb
  begin
    next_state   = state;
    restartReq   = 1'b0;
    restartClear = 1'b0;
    case (state)
      ST_IDLE:
      begin
        if (launch)
          next_state = ST_REQ;
      end
      ST_REQ:
      begin
        restartReq = 1'b1;
        next_state = launch ? ST_REQ : ST_WAIT;
      end
      ST_WAIT:
      begin
        // a fresh update restarts the handshake so its context is honoured
        if (launch)
          next_state = ST_REQ;
        else if (sensorRestartDone)
        begin
          restartClear = 1'b1;
          next_state   = ST_IDLE;
        end
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

endmodule : ccs_restart_ctrl
`default_nettype wire

// ---- design/ccs_context_control.sv ----
// Behaviour
// - each context bit picks set A when 0, set B when 1.
// - update with bit 15 set requests a sensor restart; clear means none.
// - bit 15 clears itself once the sensor restart has happened.
// - bit 12 picks defect correction set A or B.
// - bit 10 picks resize and zoom set A or B.
// - bit 9 picks output format 2 configuration A or B.
// - bit 8 picks gamma table A or B.
// - bit 6 set stops frames reaching the host pixel output.
// - frame blanking is mainly driven by the internal sequencer.
// - bit 3 picks sensor read mode context A or B.
// - bit 2 drives the LED flash directly.
// - bit 1 picks vertical blanking set A or B.
// - bit 0 picks horizontal blanking set A or B.
`timescale 1ns/100ps
`default_nettype none
module ccs_context_control
  import ccs_pkg::*;
#(
  parameter logic [CCS_REG_W-1:0] RESET_VALUE = CCS_RESET_VALUE
)
(
  input  wire logic                 clock,
  input  wire logic                 nrst,
  input  wire logic                 hostWrEn,
  input  wire logic [CCS_REG_W-1:0] hostWrData,
  input  wire logic                 seqWrEn,
  input  wire logic [CCS_REG_W-1:0] seqWrData,
  output logic      [CCS_REG_W-1:0] rdData,
  input  wire logic                 sensorRestartDone,
  output logic                      restartReq,
  output ccs_ctx_s                  ctxSel,
  output logic                      ledFlashOn,
  output logic                      xenonArmed,
  input  wire ccs_pix_s             pixIn,
  output ccs_pix_s                  pixOut
);

  logic [CCS_REG_W-1:0] ctrl;
  logic [CCS_REG_W-1:0] next_ctrl;
  logic                 blankFrame;
  logic                 next_blankFrame;
  ccs_pix_s             next_pixOut;
  logic                 wrEn;
  logic [CCS_REG_W-1:0] wrData;
  logic                 launch;
  logic                 restartClear;

  // host and sequencer share the register; the host wins a same-cycle clash
  assign wrEn   = hostWrEn | seqWrEn;
  assign wrData = hostWrEn ? hostWrData : seqWrData;
  assign launch = wrEn & wrData[CCS_BIT_RESTART];

  ccs_restart_ctrl u_restart (
    .clock             (clock),
    .nrst              (nrst),
    .launch            (launch),
    .sensorRestartDone (sensorRestartDone),
    .restartReq        (restartReq),
    .restartClear      (restartClear)
  );

  always_comb
  begin
    next_ctrl = ctrl;
    if (restartClear)
      next_ctrl[CCS_BIT_RESTART] = 1'b0;
    // a write in the same cycle as the self-clear wins
    if (wrEn)
      next_ctrl = wrData & CCS_IMPL_MASK;
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
      ctrl <= RESET_VALUE & CCS_IMPL_MASK;
    else
      ctrl <= next_ctrl;
  end

  assign rdData = ctrl;

  // selects follow the register directly, as the pipelines expect
  assign ctxSel     = ccs_ctx_of(ctrl);
  assign ledFlashOn = ctrl[CCS_BIT_LED];
  assign xenonArmed = ctrl[CCS_BIT_XENON];

  // blanking is sampled at frame start so the host never sees half a frame
  always_comb
  begin
    next_blankFrame = blankFrame;
    if (pixIn.valid && pixIn.frameStart)
      next_blankFrame = ctrl[CCS_BIT_FBLANK];
    next_pixOut       = pixIn;
    next_pixOut.valid = pixIn.valid &&
                        !(pixIn.frameStart ? ctrl[CCS_BIT_FBLANK] : blankFrame);
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      blankFrame <= 1'b0;
      pixOut     <= '0;
    end
    else
    begin
      blankFrame <= next_blankFrame;
      pixOut     <= next_pixOut;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_launch;
    launch;
  endsequence

  sequence s_req_pulse;
    restartReq;
  endsequence

  sequence s_done_seen;
    !launch && !restartReq && sensorRestartDone;
  endsequence

  sequence s_blank_start;
    pixIn.valid && pixIn.frameStart && ctrl[CCS_BIT_FBLANK];
  endsequence

  sequence s_open_start;
    pixIn.valid && pixIn.frameStart && !ctrl[CCS_BIT_FBLANK];
  endsequence

  chk_restart_issued: assert property (s_launch |=> s_req_pulse)
    else $error("restart not requested after update with bit 15");

  chk_restart_absent: assert property ((wrEn && !launch && !restartReq &&
                                        !ctrl[CCS_BIT_RESTART]) |=> !restartReq)
    else $error("restart requested without bit 15");

  chk_restart_selfclear: assert property (
    (ctrl[CCS_BIT_RESTART] && !restartReq) ##0 s_done_seen ##0 (!wrEn)
      |=> !ctrl[CCS_BIT_RESTART])
    else $error("bit 15 not cleared after sensor restart");

  chk_restart_holds: assert property ((ctrl[CCS_BIT_RESTART] && !sensorRestartDone && !wrEn)
                                       |=> ctrl[CCS_BIT_RESTART])
    else $error("bit 15 cleared before restart occurred");

  chk_reserved_zero: assert property ((rdData & ~CCS_IMPL_MASK) == '0)
    else $error("reserved bits read nonzero");

  chk_ctx_follow: assert property (wrEn |=> (ctxSel.defect == $past(wrData[CCS_BIT_DEFECT])
                                   && ctxSel.gamma == $past(wrData[CCS_BIT_GAMMA])
                                   && ctxSel.resize == $past(wrData[CCS_BIT_RESIZE])))
    else $error("context selects do not follow write");

  chk_led_follow: assert property (wrEn |=> ledFlashOn == $past(wrData[CCS_BIT_LED]))
    else $error("LED flash does not follow bit 2");

  chk_xenon_arm: assert property (wrEn |=> xenonArmed == $past(wrData[CCS_BIT_XENON]))
    else $error("xenon arm does not follow bit 7");

  chk_blank_gate: assert property ((pixIn.valid && pixIn.frameStart && ctrl[CCS_BIT_FBLANK])
                                    |=> !pixOut.valid)
    else $error("blanked frame start reached host");

  chk_pass_frame: assert property ((pixIn.valid && pixIn.frameStart && !ctrl[CCS_BIT_FBLANK])
                                    |=> pixOut.valid && pixOut.data == $past(pixIn.data))
    else $error("unblanked frame start lost");

  chk_resize_follow: assert property (
    wrEn |=> ctxSel.resize == $past(wrData[CCS_BIT_RESIZE]))
    else $error("resize select does not follow bit 10");

  chk_fmt_follow: assert property (
    wrEn |=> ctxSel.fmt2 == $past(wrData[CCS_BIT_FMT2]))
    else $error("output format select does not follow bit 9");

  chk_gamma_follow: assert property (
    wrEn |=> ctxSel.gamma == $past(wrData[CCS_BIT_GAMMA]))
    else $error("gamma select does not follow bit 8");

  chk_readmode_follow: assert property (
    wrEn |=> ctxSel.readMode == $past(wrData[CCS_BIT_RDMODE]))
    else $error("read mode select does not follow bit 3");

  chk_vblank_follow: assert property (
    wrEn |=> ctxSel.vBlank == $past(wrData[CCS_BIT_VBLANK]))
    else $error("vertical blanking select does not follow bit 1");

  chk_hblank_follow: assert property (
    wrEn |=> ctxSel.hBlank == $past(wrData[CCS_BIT_HBLANK]))
    else $error("horizontal blanking select does not follow bit 0");

  // the self-clear touches bit 15 only, so no select may move without a write
  chk_ctx_stable: assert property (
    !wrEn |=> $stable(ctxSel) && $stable(ledFlashOn) && $stable(xenonArmed))
    else $error("selects changed without a write");

  chk_req_single: assert property ((restartReq && !launch) |=> !restartReq)
    else $error("restart request held beyond one cycle");

  chk_host_wins: assert property (
    (hostWrEn && seqWrEn) |=> rdData == ($past(hostWrData) & CCS_IMPL_MASK))
    else $error("host write lost a clash with the sequencer");

  chk_seq_write: assert property (
    (seqWrEn && !hostWrEn) |=> rdData == ($past(seqWrData) & CCS_IMPL_MASK))
    else $error("sequencer write not taken");

  // the valid pixel right after a blanked frame start is blanked too
  chk_blank_hold: assert property (
    s_blank_start ##1 (pixIn.valid && !pixIn.frameStart) |=> !pixOut.valid)
    else $error("blanked frame pixel reached host");

  chk_pass_hold: assert property (
    s_open_start ##1 (pixIn.valid && !pixIn.frameStart) |=> pixOut.valid)
    else $error("open frame pixel lost");

  chk_pix_copy: assert property (
    pixIn.valid |=> pixOut.data == $past(pixIn.data) &&
                    pixOut.frameStart == $past(pixIn.frameStart))
    else $error("pixel data or frame start not copied");

endmodule : ccs_context_control
`default_nettype wire

// ---- verification/ccs_sensor_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module ccs_sensor_model
#(
  parameter int DELAY = 4
)
(
  input  wire logic clock,
  input  wire logic restartReq,
  output logic      restartDone
);
  // done comes a few cycles after a request; a request reloads the count but does not stop a done already due
  int cnt = 0;
  always @(posedge clock)
  begin
    restartDone <= (cnt == 1);
    if (restartReq)
      cnt <= DELAY;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
endmodule : ccs_sensor_model
`default_nettype wire

// ---- verification/tb_camera_context_switch_control.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_camera_context_switch_control
  import ccs_pkg::*;
;
  logic                 clock;
  logic                 nrst;
  logic                 hostWrEn;
  logic                 seqWrEn;
  logic [CCS_REG_W-1:0] hostWrData;
  logic [CCS_REG_W-1:0] seqWrData;
  logic [CCS_REG_W-1:0] rdData;
  logic                 sensorRestartDone;
  logic                 restartReq;
  logic                 ledFlashOn;
  logic                 xenonArmed;
  ccs_ctx_s             ctxSel;
  ccs_pix_s             pixIn;
  ccs_pix_s             pixOut;
  int                   badCount = 0;
  int                   comparisons = 0;
  int                   pos [7] = '{12, 10, 9, 8, 3, 1, 0};

  ccs_context_control dut (.clock(clock), .nrst(nrst), .hostWrEn(hostWrEn),
    .hostWrData(hostWrData), .seqWrEn(seqWrEn), .seqWrData(seqWrData), .rdData(rdData),
    .sensorRestartDone(sensorRestartDone), .restartReq(restartReq), .ctxSel(ctxSel),
    .ledFlashOn(ledFlashOn), .xenonArmed(xenonArmed), .pixIn(pixIn), .pixOut(pixOut));

  ccs_sensor_model sensor (.clock(clock), .restartReq(restartReq),
    .restartDone(sensorRestartDone));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      badCount++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // seq selects the sequencer port instead of the host port
  task automatic write(input logic seq, input logic [15:0] d);
    @(negedge clock);
    hostWrEn   = !seq;
    seqWrEn    = seq;
    hostWrData = d;
    seqWrData  = d;
    @(negedge clock);
    hostWrEn   = 1'b0;
    seqWrEn    = 1'b0;
  endtask : write

  // two-pixel frame; pixOut is registered, so the second pixel is looked at after
  task automatic frame(input logic [7:0] d);
    @(negedge clock);
    pixIn = '{1'b1, 1'b1, d};
    @(negedge clock);
    pixIn = '{1'b1, 1'b0, d};
    @(negedge clock);
    pixIn = '0;
  endtask : frame

  task automatic conclude();
    $display("comparisons=%0d mismatches=%0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // whole run is some 54 cycles; this watchdog fires after 2000
  initial
  begin
    #20000;
    badCount++;
    conclude();
  end

  initial
  begin
    nrst = 1'b0;
    hostWrEn = 1'b0;
    seqWrEn = 1'b0;
    hostWrData = 16'h0000;
    seqWrData = 16'h0000;
    pixIn = '0;
    repeat (12) @(negedge clock);
    nrst = 1'b1;
    check(rdData, 16'h0000);
    write(1'b0, 16'h7fff);
    check(rdData, 16'h17cf);
    check({9'h0, ctxSel}, 16'h007f);
    check({15'h0, ledFlashOn}, 16'h0001);
    check({15'h0, xenonArmed}, 16'h0001);
    for (int i = 0; i < 7; i++)
    begin
      write(1'b0, 16'h0001 << pos[i]);
      check({9'h0, ctxSel}, 16'h0001 << (6 - i));
    end
    check({15'h0, ledFlashOn}, 16'h0000);
    check({15'h0, xenonArmed}, 16'h0000);
    $display("test context bits done");
    write(1'b0, 16'h8000);
    check({15'h0, restartReq}, 16'h0001);
    check(rdData, 16'h8000);
    for (int i = 0; i < 20 && rdData[15] !== 1'b0; i++)
      @(negedge clock);
    check(rdData, 16'h0000);
    write(1'b0, 16'h0001);
    check({15'h0, restartReq}, 16'h0000);
    $display("test restart done");
    write(1'b1, 16'h0040);
    check(rdData, 16'h0040);
    frame(8'h5a);
    check({7'h0, pixOut.valid, pixOut.data}, 16'h005a);
    write(1'b0, 16'h0000);
    frame(8'ha5);
    check({7'h0, pixOut.valid, pixOut.data}, 16'h01a5);
    $display("test blanking done");
    @(negedge clock);
    hostWrEn   = 1'b1;
    seqWrEn    = 1'b1;
    hostWrData = 16'h0004;
    seqWrData  = 16'h0080;
    @(negedge clock);
    hostWrEn   = 1'b0;
    seqWrEn    = 1'b0;
    check(rdData, 16'h0004);
    check({15'h0, xenonArmed}, 16'h0000);
    $display("test write clash done");
    write(1'b0, 16'h0000);
    check({9'h0, ctxSel}, 16'h0000);
    write(1'b0, 16'h170b);
    check(rdData, 16'h170b);
    check({9'h0, ctxSel}, 16'h007f);
    $display("test preview and snapshot done");
    conclude();
  end
endmodule : tb_camera_context_switch_control
`default_nettype wire
